// file: rtl/spip_pkg.sv
/*
 * Shared constants for the byte-wide SPI port: register offsets, field
 * positions, reset values and rate table.
 * Assumes an 8-bit register port addressed by printed offset.
 */
package spip_pkg;
	localparam logic [7:0] SPIP_ADDR_CTRL = 8'h2c;
	localparam logic [7:0] SPIP_ADDR_STAT = 8'h2d;
	localparam logic [7:0] SPIP_ADDR_DATA = 8'h2e;
	localparam logic [7:0] SPIP_CTRL_RST  = 8'h00;
	localparam logic [7:0] SPIP_DATA_RST  = 8'h00;
	localparam int         CB_IRQ_EN      = 7;
	localparam int         CB_PORT_EN     = 6;
	localparam int         CB_ORDER       = 5;
	localparam int         CB_MASTER      = 4;
	localparam int         CB_CLOCK_POLARITY        = 3;
	localparam int         CB_CLOCK_PHASE        = 2;
	localparam int         CB_RATE_HI     = 1;
	localparam int         CB_RATE_LO     = 0;
	localparam int         SB_DONE        = 7;
	localparam int         SB_WRITE_COLLISION_FLAG        = 6;
	localparam int         SB_DOUBLE      = 0;
	localparam int         HALF_W         = 7;
	localparam logic [3:0] SPIP_EDGES     = 4'hf;
	localparam logic [3:0] SPIP_BITS      = 4'h8;
	localparam int         MISO_LAG       = 2;

	// Half an SCK period in mclk cycles; full dividers 4/16/64/128, halved when doubled
	function automatic logic [HALF_W-1:0] spip_half(input logic dbl, input logic [1:0] rate);
		logic [HALF_W-1:0] h;
		unique case (rate)
			2'h0: h = 7'h02;
			2'h1: h = 7'h08;
			2'h2: h = 7'h20;
			2'h3: h = 7'h40;
		endcase
		return dbl ? (h >> 1) : h;
	endfunction : spip_half
endpackage : spip_pkg

// file: rtl/spip_sync.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit is an independent level from outside the mclk domain.
 */
`timescale 1ns/100ps
`default_nettype none
module spip_sync #(
	parameter int W = 3
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : spip_sync
`default_nettype wire

// file: rtl/spip_clkgen.sv
/*
 * SCK half-period divider: one-cycle tick every half mclk cycles while run.
 * Assumes half is at least one and stable during a byte.
 */
`timescale 1ns/100ps
`default_nettype none
module spip_clkgen (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic                        run,
	input  wire logic [spip_pkg::HALF_W-1:0] half,
	output var  logic                        tick
);
	import spip_pkg::*;

	logic [HALF_W-1:0] cnt_q;

	always_comb begin
		tick = run && (cnt_q == half - 7'h01);
	end

	always_ff @(posedge mclk) begin
		if (rst || !run || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end
endmodule : spip_clkgen
`default_nettype wire

// file: rtl/spip_top.sv
/*
 * Byte-wide SPI port, master or slave, with control, status and data
 * registers on a plain strobe port.
 * Assumes pin direction bits, the port value for slave select and the
 * global interrupt enable come from mclk logic; pins need resolution outside.
 */
// Function
// - Slave selected: active, drive MISO only if its direction bit says output.
// - Slave deselected: all pins inputs, incoming data ignored.
// - Slave select rising resets bit counters and drops partial byte.
// - Master with select as output: select pin is a plain output.
// - Select driven low as input in master: drop master, SCK and MOSI to input.
// - That demotion sets the completion flag, may request interrupt.
// - Shift and sample on opposite SCK edges in all four modes.
// - Polarity one idles SCK high, zero idles low.
// - Phase zero samples on leading edge, phase one on trailing.
// - Order bit set sends LSB first, clear sends MSB first.
// - No SPI operation unless enable bit is one.
// - Master divides clock by 4, 16, 64 or 128.
// - Double speed halves those dividers to 2, 8, 32, 64.
// - Slave ignores rate bits, timed by incoming SCK.
// - Transfer end sets completion flag and may request interrupt.
// - Flag clears on vector ack or status read then data access.
// - Data write during transfer sets write collision flag.
// - Status read with collision then data access clears both flags.
// - Status bits five to one read zero.
// - Data write starts transfer; data read returns receive buffer.
// - Master write runs clock for eight bits, stops, sets flag.
// - Single buffered transmit, double buffered receive.
`timescale 1ns/100ps
`default_nettype none
module spip_top (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	input  wire logic       global_irq_en,
	input  wire logic       irq_ack,
	output var  logic       xfer_irq,
	input  wire logic       dir_sck,
	input  wire logic       dir_mosi,
	input  wire logic       dir_miso,
	input  wire logic       dir_ss,
	input  wire logic       ss_port_val,
	input  wire logic       sck_in,
	output var  logic       sck_out,
	output var  logic       sck_oe,
	input  wire logic       mosi_in,
	output var  logic       mosi_out,
	output var  logic       mosi_oe,
	input  wire logic       miso_in,
	output var  logic       miso_out,
	output var  logic       miso_oe,
	input  wire logic       ss_n_in,
	output var  logic       ss_n_out,
	output var  logic       ss_n_oe
);
	import spip_pkg::*;

	// ************************************************************
	// Registers and pin sampling
	// ************************************************************
	logic [7:0]        ctrl_q;
	logic              dbl_q;
	logic              done_q;
	logic              write_collision_flag_q;
	logic              arm_done_q;
	logic              arm_write_collision_flag_q;
	logic [7:0]        txbuf_q;
	logic [7:0]        shreg_q;
	logic [7:0]        rxbuf_q;
	logic [7:0]        rdata_q;
	logic              run_q;
	logic              sck_q;
	logic [3:0]        edge_q;
	logic [3:0]        setn_q;
	logic [3:0]        rxn_q;
	logic              rx_full_q;
	logic [MISO_LAG-1:0] lag_q;
	logic              out_q;
	logic [2:0]        pins_s;
	logic              sck_s_q;
	logic              ss_s_q;
	logic              tick;

	logic en;
	logic master;
	logic clock_polarity;
	logic clock_phase;
	logic ss_low;
	logic sel;
	logic fault;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_data;
	logic rd_stat;
	logic rd_data;
	logic data_acc;
	logic busy;
	logic start;
	logic m_lead;
	logic m_samp;
	logic m_setup;
	logic s_rise;
	logic s_fall;
	logic s_lead;
	logic s_samp;
	logic s_setup;
	logic ss_rise;
	logic samp;
	logic rx_bit;
	logic setup;
	logic byte_end;
	logic [3:0] setn_d;

	assign en       = ctrl_q[CB_PORT_EN];
	assign master   = ctrl_q[CB_MASTER];
	assign clock_polarity     = ctrl_q[CB_CLOCK_POLARITY];
	assign clock_phase     = ctrl_q[CB_CLOCK_PHASE];
	assign wr_ctrl  = wr && addr == SPIP_ADDR_CTRL;
	assign wr_stat  = wr && addr == SPIP_ADDR_STAT;
	assign wr_data  = wr && addr == SPIP_ADDR_DATA;
	assign rd_stat  = rd && addr == SPIP_ADDR_STAT;
	assign rd_data  = rd && addr == SPIP_ADDR_DATA;
	assign data_acc = wr_data || rd_data;

	// SCK, MOSI and select pass two flops; MISO too, so its lag is fixed
	spip_sync #(
		.W(3)
	) u_sync (
		.mclk(mclk),
		.rst (rst),
		.d   ({ss_n_in, sck_in, mosi_in}),
		.q   (pins_s)
	);

	logic miso_meta_q;
	logic miso_s_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			miso_meta_q <= 1'b0;
			miso_s_q    <= 1'b0;
		end else begin
			miso_meta_q <= miso_in;
			miso_s_q    <= miso_meta_q;
		end
	end

	// Edge history on synchronised copies only
	always_ff @(posedge mclk) begin
		if (rst) begin
			sck_s_q <= 1'b0;
			ss_s_q  <= 1'b1;
		end else begin
			sck_s_q <= pins_s[1];
			ss_s_q  <= pins_s[2];
		end
	end

	assign ss_low  = !pins_s[2];
	assign sel     = en && !master && ss_low;
	assign ss_rise = pins_s[2] && !ss_s_q;
	assign s_rise  = pins_s[1] && !sck_s_q;
	assign s_fall  = !pins_s[1] && sck_s_q;
	assign s_lead  = clock_polarity ? s_fall : s_rise;
	// Slave edges gated by select; deselected slave sees nothing
	assign s_samp  = sel && (clock_phase ? !s_lead && (s_rise || s_fall) : s_lead);
	assign s_setup = sel && (clock_phase ? s_lead : !s_lead && (s_rise || s_fall));
	assign fault   = en && master && !dir_ss && ss_low;

	// ************************************************************
	// Master clock generator
	// ************************************************************
	spip_clkgen u_clkgen (
		.mclk(mclk),
		.rst (rst),
		.run (run_q),
		.half(spip_half(dbl_q, ctrl_q[CB_RATE_HI:CB_RATE_LO])),
		.tick(tick)
	);

	assign busy    = run_q || rx_full_q || rxn_q != 4'h0;
	assign start   = wr_data && !busy && en && master && !fault;
	assign m_lead  = tick && !edge_q[0];
	assign m_samp  = tick && (m_lead ^ clock_phase);
	assign m_setup = tick && !(m_lead ^ clock_phase);

	always_ff @(posedge mclk) begin
		if (rst || !en || fault) begin
			run_q  <= 1'b0;
			sck_q  <= 1'b0;
			edge_q <= 4'h0;
		end else if (start) begin
			run_q  <= 1'b1;
			sck_q  <= clock_polarity;
			edge_q <= 4'h0;
		end else if (tick) begin
			sck_q  <= !sck_q;
			edge_q <= edge_q + 4'h1;
			// Clock stops after the sixteenth edge
			if (edge_q == SPIP_EDGES) begin
				run_q <= 1'b0;
			end
		end else if (!run_q) begin
			sck_q <= clock_polarity;
		end
	end

	// Master samples MISO after the synchroniser lag
	always_ff @(posedge mclk) begin
		if (rst || !en || fault) begin
			lag_q <= '0;
		end else begin
			lag_q <= {lag_q[MISO_LAG-2:0], m_samp && master};
		end
	end

	// ************************************************************
	// Shift logic shared by both roles
	// ************************************************************
	assign samp     = master ? lag_q[MISO_LAG-1] : s_samp;
	assign rx_bit   = master ? miso_s_q : pins_s[0];
	assign setup    = master ? m_setup : s_setup;
	assign byte_end = rx_full_q && !run_q;

	always_comb begin
		setn_d = setn_q;
		if (start || ss_rise) begin
			setn_d = 4'h0;
		end else if (setup && setn_q != SPIP_BITS) begin
			setn_d = setn_q + 4'h1;
		end
	end

	// Index of the bit on the data line; phase one waits for the first edge
	function automatic logic tx_pick(input logic [7:0] b, input logic [3:0] n,
		input logic ph, input logic lsb);
		logic [2:0] i;
		i = ph ? ((n == 4'h0) ? 3'h0 : 3'(n - 4'h1)) : 3'(n);
		return lsb ? b[i] : b[3'h7 - i];
	endfunction : tx_pick

	always_ff @(posedge mclk) begin
		if (rst || !en || fault) begin
			setn_q <= 4'h0;
			out_q  <= 1'b0;
		end else begin
			setn_q <= setn_d;
			// Start takes the new byte at once; the buffer lands a cycle late
			out_q  <= tx_pick(start ? wdata : txbuf_q, setn_d, clock_phase, ctrl_q[CB_ORDER]);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !en || fault || start || (!master && ss_rise)) begin
			rxn_q     <= 4'h0;
			rx_full_q <= 1'b0;
		end else if (byte_end) begin
			rxn_q     <= 4'h0;
			rx_full_q <= 1'b0;
		end else if (samp && !rx_full_q) begin
			rxn_q     <= rxn_q + 4'h1;
			rx_full_q <= rxn_q == SPIP_BITS - 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			shreg_q <= 8'h00;
		end else if (samp && !rx_full_q) begin
			shreg_q <= ctrl_q[CB_ORDER] ? {rx_bit, shreg_q[7:1]} : {shreg_q[6:0], rx_bit};
		end
	end

	// Receive buffer holds until the next whole byte replaces it
	always_ff @(posedge mclk) begin
		if (rst) begin
			rxbuf_q <= SPIP_DATA_RST;
		end else if (byte_end) begin
			rxbuf_q <= shreg_q;
		end
	end

	// Single transmit buffer: a write during a byte is refused
	always_ff @(posedge mclk) begin
		if (rst) begin
			txbuf_q <= SPIP_DATA_RST;
		end else if (wr_data && !busy) begin
			txbuf_q <= wdata;
		end
	end

	// ************************************************************
	// Control and status
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= SPIP_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= wdata;
		end else if (fault) begin
			ctrl_q[CB_MASTER] <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dbl_q <= 1'b0;
		end else if (wr_stat) begin
			dbl_q <= wdata[SB_DOUBLE];
		end
	end

	// Clear needs a status read that saw the flag; a new set wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			arm_done_q <= 1'b0;
			arm_write_collision_flag_q <= 1'b0;
		end else if (data_acc) begin
			arm_done_q <= 1'b0;
			arm_write_collision_flag_q <= 1'b0;
		end else if (rd_stat) begin
			arm_done_q <= done_q;
			arm_write_collision_flag_q <= write_collision_flag_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if (byte_end || fault) begin
			done_q <= 1'b1;
		end else if (irq_ack || (data_acc && (arm_done_q || arm_write_collision_flag_q))) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			write_collision_flag_q <= 1'b0;
		end else if (wr_data && busy) begin
			write_collision_flag_q <= 1'b1;
		end else if (data_acc && arm_write_collision_flag_q) begin
			write_collision_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !rd) begin
			rdata_q <= 8'h00;
		end else begin
			unique case (addr)
				SPIP_ADDR_CTRL: rdata_q <= ctrl_q;
				SPIP_ADDR_STAT: rdata_q <= {done_q, write_collision_flag_q, 5'h00, dbl_q};
				SPIP_ADDR_DATA: rdata_q <= rxbuf_q;
				default:        rdata_q <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Pins and interrupt
	// ************************************************************
	assign rdata    = rdata_q;
	assign xfer_irq = done_q && ctrl_q[CB_IRQ_EN] && global_irq_en;
	assign sck_out  = sck_q;
	assign sck_oe   = en && master && dir_sck;
	assign mosi_out = out_q;
	assign mosi_oe  = en && master && dir_mosi;
	assign miso_out = out_q;
	assign miso_oe  = sel && dir_miso;
	assign ss_n_out = ss_port_val;
	assign ss_n_oe  = dir_ss && !(en && !master);

	// ************************************************************
	// Checks
	// ************************************************************
	// Longest byte is sixteen halves of 64 cycles; a counter bounds it
	localparam logic [10:0] RUN_LIMIT = 11'h44c;
	logic [10:0] run_len_q;

	always_ff @(posedge mclk) begin
		if (rst || !run_q) begin
			run_len_q <= 11'h000;
		end else if (run_len_q != 11'h7ff) begin
			run_len_q <= run_len_q + 11'h001;
		end
	end

	sequence s_begin;
		start;
	endsequence
	sequence s_last_edge;
		en && !fault && run_q && tick && edge_q == SPIP_EDGES;
	endsequence
	sequence s_finish;
		!run_q ##[0:4] done_q;
	endsequence

	property p_master_start;
		@(posedge mclk) disable iff (rst)
		s_begin |=> run_q && edge_q == 4'h0;
	endproperty
	a_master_start: assert property (p_master_start) else $error("master byte did not start");

	property p_byte_len;
		@(posedge mclk) disable iff (rst)
		run_q |-> run_len_q < RUN_LIMIT;
	endproperty
	a_byte_len: assert property (p_byte_len) else $error("master byte ran too long");

	property p_master_byte;
		@(posedge mclk) disable iff (rst)
		s_last_edge |=> s_finish;
	endproperty
	a_master_byte: assert property (p_master_byte) else $error("master byte did not finish");

	property p_fault;
		@(posedge mclk) disable iff (rst)
		fault && !wr_ctrl |=> !ctrl_q[CB_MASTER] && done_q && !sck_oe && !mosi_oe;
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not handled");

	property p_write_collision_flag;
		@(posedge mclk) disable iff (rst)
		wr_data && busy |=> write_collision_flag_q && $stable(txbuf_q);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

	property p_resv;
		@(posedge mclk) disable iff (rst)
		rd_stat |=> rdata[5:1] == 5'h00 && rdata[7] == $past(done_q);
	endproperty
	a_resv: assert property (p_resv) else $error("status read wrong");

	property p_rx_read;
		@(posedge mclk) disable iff (rst)
		rd_data |=> rdata == $past(rxbuf_q);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("data read wrong");

	property p_passive;
		@(posedge mclk) disable iff (rst)
		!master && pins_s[2] |-> !miso_oe && !sck_oe && !mosi_oe;
	endproperty
	a_passive: assert property (p_passive) else $error("deselected slave drives");

	property p_ss_reset;
		@(posedge mclk) disable iff (rst)
		!master && ss_rise |=> rxn_q == 4'h0 && !rx_full_q;
	endproperty
	a_ss_reset: assert property (p_ss_reset) else $error("select rise kept bits");

	property p_idle_pol;
		@(posedge mclk) disable iff (rst)
		en && !run_q && !start && !tick ##1 !run_q |-> sck_out == $past(clock_polarity);
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle sck level");

	property p_off;
		@(posedge mclk) disable iff (rst)
		!en |-> !sck_oe && !mosi_oe && !miso_oe ##1 !run_q && setn_q == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("disabled port active");

	property p_clear;
		@(posedge mclk) disable iff (rst)
		data_acc && arm_write_collision_flag_q && !(wr_data && busy) && !byte_end && !fault |=> !write_collision_flag_q && !done_q;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");
endmodule : spip_top
`default_nettype wire

// file: tb/spip_peer.sv
/*
 * Far-side SPI slave used while the port is master: MSB first,
 * mode given by the bench.
 * Assumes its clock, data and select come from the resolved pin wires.
 */
`timescale 1ns/100ps
`default_nettype none
module spip_peer (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	input  wire logic [7:0] tx_byte,
	output var  logic       miso,
	output var  logic [7:0] rx_byte
);
	logic [7:0] sh;

	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
		sh = 8'h00;
	end

	// Released line flips, so a stale bit can never pass for data
	always @(ss_n) begin
		if (ss_n) begin
			miso = ~miso;
		end else begin
			sh = tx_byte;
			if (!clock_phase) begin
				miso = sh[7];
			end
		end
	end

	always @(sck) begin
		if (!ss_n) begin
			if (sck == !(clock_polarity ^ clock_phase)) begin
				rx_byte = {rx_byte[6:0], mosi};
				sh = sh << 1;
			end else begin
				miso = sh[7];
			end
		end
	end
endmodule : spip_peer
`default_nettype wire

// file: tb/spip_top_bench.sv
/*
 * Self-checking bench for the SPI port: master runs against the peer,
 * slave runs with this module acting as the far master.
 * Assumes pin wires are resolved here from every party's enable.
 */
`timescale 1ns/100ps
`default_nettype none
module spip_top_bench;
	import spip_pkg::*;
	logic       mclk, rst, wr, rd, gie, ack, clock_polarity, clock_phase;
	logic [7:0] addr, wdata, rdata, ptx, prx, got;
	logic       d_sck, d_mosi, d_miso, d_ss, ssv, t_sck, t_mosi, t_ss_n, p_miso;
	logic       sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e, ss_o, ss_e, irq;
	wire logic  sck_w, mosi_w, miso_w, ss_w;
	int         n_fail, cmp_count;

	assign sck_w  = sck_e ? sck_o : t_sck;
	assign mosi_w = mosi_e ? mosi_o : t_mosi;
	assign miso_w = miso_e ? miso_o : p_miso;
	assign ss_w   = ss_e ? ss_o : t_ss_n;

	spip_top dut_u (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .global_irq_en(gie), .irq_ack(ack), .xfer_irq(irq),
		.dir_sck(d_sck), .dir_mosi(d_mosi), .dir_miso(d_miso), .dir_ss(d_ss),
		.ss_port_val(ssv), .sck_in(sck_w), .sck_out(sck_o), .sck_oe(sck_e),
		.mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_e), .miso_in(miso_w),
		.miso_out(miso_o), .miso_oe(miso_e), .ss_n_in(ss_w), .ss_n_out(ss_o),
		.ss_n_oe(ss_e)
	);
	spip_peer peer_u (
		.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .clock_polarity(clock_polarity), .clock_phase(clock_phase),
		.tx_byte(ptx), .miso(p_miso), .rx_byte(prx)
	);

	always #25 mclk = ~mclk;

	/********************************
	 * Bus and check tasks
	 ********************************/
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		// Idle edge, so a following write never re-raises wr in this step
		@(posedge mclk);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		d = rdata;
	endtask : rreg

	task automatic wait_done();
		int i;
		for (i = 0; i < 3000; i++) begin
			rreg(SPIP_ADDR_STAT, got);
			if (got[SB_DONE] === 1'b1)
				break;
		end
		if (i == 3000) begin
			n_fail++;
			wrap_up();
		end
	endtask : wait_done

	function automatic logic [7:0] rev(input logic [7:0] x);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = x[7 - i];
		return r;
	endfunction : rev

	/********************************
	 * Scenarios
	 ********************************/
	task automatic m_xfer(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] pb);
		ptx = pb;
		clock_polarity = ctl[CB_CLOCK_POLARITY];
		clock_phase = ctl[CB_CLOCK_PHASE];
		ssv <= 1'b1;
		wreg(SPIP_ADDR_CTRL, ctl);
		// Let the idle level settle before the peer is selected
		@(posedge mclk);
		ssv <= 1'b0;
		wreg(SPIP_ADDR_DATA, tx);
		wait_done();
		rreg(SPIP_ADDR_DATA, got);
		check(got, ctl[CB_ORDER] ? rev(pb) : pb);
		check(prx, ctl[CB_ORDER] ? rev(tx) : tx);
		check({7'h00, sck_o}, {7'h00, clock_polarity});
		check({6'h00, ss_e, ss_o}, 8'h02);
	endtask : m_xfer

	task automatic rate_chk();
		logic [7:0] half_tab [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};
		int c;
		for (int k = 0; k < 8; k++) begin
			wreg(SPIP_ADDR_STAT, {7'h00, k[2]});
			wreg(SPIP_ADDR_CTRL, {6'h14, k[1:0]});
			wreg(SPIP_ADDR_DATA, 8'ha5);
			c = 0;
			while (sck_o !== 1'b1 && c < 300) begin
				@(posedge mclk);
				c++;
			end
			c = 0;
			while (sck_o === 1'b1 && c < 300) begin
				@(posedge mclk);
				c++;
			end
			check(8'(c), half_tab[k]);
			wait_done();
			rreg(SPIP_ADDR_DATA, got);
		end
	endtask : rate_chk

	task automatic write_collision_flag_irq();
		gie <= 1'b1;
		ssv <= 1'b1;
		wreg(SPIP_ADDR_STAT, 8'h00);
		wreg(SPIP_ADDR_CTRL, 8'hd0);
		ssv <= 1'b0;
		wreg(SPIP_ADDR_DATA, 8'h3c);
		@(posedge mclk);
		wreg(SPIP_ADDR_DATA, 8'hff);
		wait_done();
		check(got, 8'hc0);
		check({7'h00, irq}, 8'h01);
		rreg(SPIP_ADDR_DATA, got);
		check(prx, 8'h3c);
		rreg(SPIP_ADDR_STAT, got);
		check(got, 8'h00);
		wreg(SPIP_ADDR_DATA, 8'h81);
		wait_done();
		ack <= 1'b1;
		@(posedge mclk);
		ack <= 1'b0;
		@(posedge mclk);
		check({7'h00, irq}, 8'h00);
		gie <= 1'b0;
	endtask : write_collision_flag_irq

	task automatic mode_fault();
		wreg(SPIP_ADDR_CTRL, 8'h50);
		d_ss <= 1'b0;
		t_ss_n <= 1'b0;
		// Two sync flops plus the demote cycle
		repeat (5) @(posedge mclk);
		rreg(SPIP_ADDR_CTRL, got);
		check(got, 8'h40);
		check({6'h00, sck_e, mosi_e}, 8'h00);
		rreg(SPIP_ADDR_STAT, got);
		check(got, 8'h80);
		rreg(SPIP_ADDR_DATA, got);
		t_ss_n <= 1'b1;
		// Raised select must clear the sync flops before master returns
		repeat (3) @(posedge mclk);
		wreg(SPIP_ADDR_CTRL, 8'h50);
		rreg(SPIP_ADDR_CTRL, got);
		check(got, 8'h50);
	endtask : mode_fault

	task automatic s_bits(input logic [7:0] b, input int n, output logic [7:0] so);
		repeat (5) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			t_mosi <= b[7 - i];
			repeat (5) @(posedge mclk);
			t_sck <= 1'b1;
			so = {so[6:0], miso_w};
			repeat (5) @(posedge mclk);
			t_sck <= 1'b0;
		end
		repeat (5) @(posedge mclk);
	endtask : s_bits

	task automatic slave_rx();
		logic [7:0] so;
		d_miso <= 1'b1;
		wreg(SPIP_ADDR_CTRL, 8'h40);
		wreg(SPIP_ADDR_DATA, 8'h96);
		t_ss_n <= 1'b0;
		s_bits(8'h69, 8, so);
		check(so, 8'h96);
		check({7'h00, miso_e}, 8'h01);
		t_ss_n <= 1'b1;
		wait_done();
		rreg(SPIP_ADDR_DATA, got);
		check(got, 8'h69);
		check({7'h00, miso_e}, 8'h00);
		s_bits(8'hff, 8, so);
		rreg(SPIP_ADDR_STAT, got);
		check(got, 8'h00);
		t_ss_n <= 1'b0;
		s_bits(8'he0, 3, so);
		t_ss_n <= 1'b1;
		repeat (5) @(posedge mclk);
		t_ss_n <= 1'b0;
		s_bits(8'h3a, 8, so);
		t_ss_n <= 1'b1;
		wait_done();
		rreg(SPIP_ADDR_DATA, got);
		check(got, 8'h3a);
	endtask : slave_rx

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{wr, rd, gie, ack, clock_polarity, clock_phase, d_miso, t_sck, t_mosi} = '0;
		{d_sck, d_mosi, d_ss, ssv, t_ss_n} = '1;
		{addr, wdata, ptx} = '0;
		n_fail = 0;
		cmp_count = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rreg(SPIP_ADDR_CTRL, got);
		check(got, SPIP_CTRL_RST);
		rreg(8'h2f, got);
		check(got, 8'h00);
		wreg(SPIP_ADDR_STAT, 8'hff);
		rreg(SPIP_ADDR_STAT, got);
		check(got, 8'h01);
		wreg(SPIP_ADDR_STAT, 8'h00);
		for (int m = 0; m < 4; m++)
			m_xfer({4'h5, m[1:0], 2'h0}, 8'hb4 + 8'(m), 8'h1d ^ 8'(m));
		m_xfer(8'h70, 8'hc1, 8'h5e);
		rate_chk();
		write_collision_flag_irq();
		mode_fault();
		slave_rx();
		wrap_up();
	end
endmodule : spip_top_bench
`default_nettype wire
